// ==== rssx_exec.sv ====
// Execution unit for rotate right, set file and sleep instructions
`timescale 1ns/1ps
module rssx_exec
  import rssx_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Instruction
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic i_ext_set_en,
  // Core state
  input wire logic [3:0] i_bank_select_reg,
  input wire logic [11:0] i_index_base,
  input wire logic [7:0] i_file_rd_data,
  // Wake sources
  input wire logic i_wake_wdt,
  input wire logic i_wake_other,
  // File read address, file and working register writes
  output logic [11:0] o_file_rd_addr,
  output rssx_file_wr_t o_file_wr,
  output logic o_wreg_we,
  output logic [7:0] o_wreg_data,
  // Flags
  output logic o_flag_we,
  output logic o_neg_flag,
  output logic o_zero_flag,
  output rssx_status_t o_status,
  // Power control, ready and phase
  output logic o_wdt_clear,
  output logic o_sleeping,
  output logic o_osc_halt,
  output logic o_instr_ready,
  output rssx_phase_t o_phase
);

  // ****************************************
  // Reset and wake synchronisers
  // ****************************************
  logic rst_meta_r;
  logic rst_sync_r;
  logic [1:0] wdt_sync_r;
  logic [1:0] oth_sync_r;
  logic wake_wdt;
  logic wake_oth;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      wdt_sync_r <= 2'b00;
      oth_sync_r <= 2'b00;
    end else begin
      wdt_sync_r <= {wdt_sync_r[0], i_wake_wdt};
      oth_sync_r <= {oth_sync_r[0], i_wake_other};
    end
  end

  assign wake_wdt = wdt_sync_r[1];
  assign wake_oth = oth_sync_r[1];

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [11:0] rssx_eff_addr(
    input logic [15:0] instr,
    input logic ext_en,
    input logic [3:0] bank,
    input logic [11:0] index_base
  );
    logic [7:0] f;
    f = instr[7:0];
    if (!instr[RSSX_BIT_ACCESS] && ext_en && f <= RSSX_INDEXED_MAX) begin
      rssx_eff_addr = 12'(index_base + {4'h0, f});
    end else if (!instr[RSSX_BIT_ACCESS]) begin
      rssx_eff_addr = (f < RSSX_ACCESS_SPLIT) ?
        {RSSX_ACCESS_LOW_BANK, f} : {RSSX_ACCESS_HIGH_BANK, f};
    end else begin
      rssx_eff_addr = {bank, f};
    end
  endfunction : rssx_eff_addr

  function automatic logic rssx_is_rotate(input logic [15:0] instr);
    rssx_is_rotate = instr[RSSX_OPC6_HI:RSSX_OPC6_LO] ==
      RSSX_OPC_ROTATE_RIGHT_NO_CARRY;
  endfunction : rssx_is_rotate

  function automatic logic rssx_is_set_file(input logic [15:0] instr);
    rssx_is_set_file = instr[RSSX_OPC6_HI:RSSX_OPC7_LO] ==
      RSSX_OPC_SET_FILE_ALL_ONES;
  endfunction : rssx_is_set_file

  function automatic logic rssx_is_sleep(input logic [15:0] instr);
    rssx_is_sleep = instr == RSSX_OPC_SLEEP;
  endfunction : rssx_is_sleep

  // ****************************************
  // Four-phase sequencer
  // ****************************************
  rssx_phase_t phase_r;
  logic [15:0] instr_r;
  logic busy_r;
  logic sleep_r;
  logic [11:0] addr_r;
  logic [7:0] result_r;
  logic take;
  logic is_rot;
  logic is_set;
  logic is_slp;

  assign is_rot = rssx_is_rotate(instr_r);
  assign is_set = rssx_is_set_file(instr_r);
  assign is_slp = rssx_is_sleep(instr_r);

  assign o_instr_ready = !busy_r && !sleep_r;
  assign take = phase_r == RSSX_Q_DECODE && i_instr_valid && o_instr_ready;

  // Phase walk, one step per clock once taken
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      phase_r <= RSSX_Q_DECODE;
    end else begin
      case (phase_r)
        RSSX_Q_DECODE: begin
          if (take) begin
            phase_r <= RSSX_Q_READ;
          end
        end
        RSSX_Q_READ: phase_r <= RSSX_Q_PROCESS;
        RSSX_Q_PROCESS: phase_r <= RSSX_Q_WRITE;
        RSSX_Q_WRITE: phase_r <= RSSX_Q_DECODE;
        default: phase_r <= RSSX_Q_DECODE;
      endcase
    end
  end

  // Instruction word, held for the whole cycle
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      instr_r <= 16'h0000;
    end else if (take) begin
      instr_r <= i_instr;
    end
  end

  // Busy from take until the write phase ends
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      busy_r <= 1'b0;
    end else if (take) begin
      busy_r <= 1'b1;
    end else if (phase_r == RSSX_Q_WRITE) begin
      busy_r <= 1'b0;
    end
  end

  assign o_phase = phase_r;

  // ****************************************
  // Read and process
  // ****************************************
  // Effective address, latched in the read phase
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      addr_r <= 12'h000;
    end else if (phase_r == RSSX_Q_READ) begin
      addr_r <= rssx_eff_addr(instr_r, i_ext_set_en,
        i_bank_select_reg, i_index_base);
    end
  end

  // Result, formed from the file data in the process phase
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      result_r <= RSSX_ZERO_BYTE;
    end else if (phase_r == RSSX_Q_PROCESS) begin
      if (is_rot) begin
        result_r <= {i_file_rd_data[0], i_file_rd_data[7:1]};
      end else if (is_set) begin
        result_r <= RSSX_ALL_ONES;
      end else begin
        result_r <= RSSX_ZERO_BYTE;
      end
    end
  end

  assign o_file_rd_addr = addr_r;

  // ****************************************
  // Write to destination
  // ****************************************
  logic wr_phase;
  logic dest_file;
  logic file_wr_go;
  logic wreg_wr_go;
  logic sleep_go;
  logic power_down_r;
  logic time_out_r;

  assign wr_phase = phase_r == RSSX_Q_WRITE;
  assign dest_file = instr_r[RSSX_BIT_DEST];
  assign file_wr_go = wr_phase &&
    (is_set || (is_rot && dest_file));
  assign wreg_wr_go = wr_phase &&
    ((is_rot && !dest_file) || is_slp);
  assign sleep_go = wr_phase && is_slp;

  // File register port
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      o_file_wr <= '0;
    end else begin
      o_file_wr.we <= file_wr_go;
      o_file_wr.addr <= addr_r;
      o_file_wr.data <= result_r;
    end
  end

  // Working register port, sleep clears it
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      o_wreg_we <= 1'b0;
      o_wreg_data <= RSSX_ZERO_BYTE;
    end else begin
      o_wreg_we <= wreg_wr_go;
      o_wreg_data <= is_slp ? RSSX_ZERO_BYTE : result_r;
    end
  end

  // Negative and zero flags, written for rotate only
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      o_flag_we <= 1'b0;
      o_neg_flag <= 1'b0;
      o_zero_flag <= 1'b0;
    end else begin
      o_flag_we <= wr_phase && is_rot;
      o_neg_flag <= result_r[7];
      o_zero_flag <= result_r == RSSX_ZERO_BYTE;
    end
  end

  // ****************************************
  // Sleep and status flags
  // ****************************************
  // Power-down flag, only reset sets it again
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      power_down_r <= RSSX_PD_RESET;
    end else if (sleep_go) begin
      power_down_r <= 1'b0;
    end
  end

  // Time-out flag, watchdog wake clears it
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      time_out_r <= RSSX_TO_RESET;
    end else if (sleep_go) begin
      time_out_r <= 1'b1;
    end else if (sleep_r && wake_wdt) begin
      time_out_r <= 1'b0;
    end
  end

  // Watchdog and postscaler clear pulse
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      o_wdt_clear <= 1'b0;
    end else begin
      o_wdt_clear <= sleep_go;
    end
  end

  // Sleep state, left on any synchronised wake
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sleep_r <= 1'b0;
    end else if (sleep_go) begin
      sleep_r <= 1'b1;
    end else if (sleep_r && (wake_wdt || wake_oth)) begin
      sleep_r <= 1'b0;
    end
  end

  assign o_status = '{power_down_flag: power_down_r,
    time_out_flag: time_out_r};
  assign o_sleeping = sleep_r;
  assign o_osc_halt = sleep_r;

endmodule : rssx_exec

// ==== rssx_exec_properties.sv ====
// Checker for the rotate, set-file and sleep execution block
`timescale 1ns/1ps
module rssx_exec_checker
  import rssx_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Watched ports
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic i_wake_wdt,
  input wire rssx_file_wr_t o_file_wr,
  input wire logic o_wreg_we,
  input wire logic o_flag_we,
  input wire rssx_status_t o_status,
  input wire logic o_wdt_clear,
  input wire logic o_sleeping,
  input wire logic o_osc_halt,
  input wire logic o_instr_ready,
  input wire rssx_phase_t o_phase
);
  // ********
  // Accepted instructions
  // ********
  logic tk, rot, set_file_all_ones_op, slp;
  assign tk = i_instr_valid && o_instr_ready;
  assign rot = tk && i_instr[15:10] == RSSX_OPC_ROTATE_RIGHT_NO_CARRY;
  assign set_file_all_ones_op = tk && i_instr[15:9] == RSSX_OPC_SET_FILE_ALL_ONES;
  assign slp = tk && i_instr == RSSX_OPC_SLEEP;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  phase_walk_a: assert property (
    tk |=> o_phase == RSSX_Q_READ ##1 o_phase == RSSX_Q_PROCESS
    ##1 o_phase == RSSX_Q_WRITE ##1 o_phase == RSSX_Q_DECODE)
    else $error("Phase sequence broken");
  busy_ready_a: assert property (
    o_phase != RSSX_Q_DECODE |-> !o_instr_ready)
    else $error("Ready while busy");
  file_dest_a: assert property (
    rot && i_instr[RSSX_BIT_DEST] |-> ##4 o_file_wr.we && !o_wreg_we)
    else $error("Rotate result not sent to file");
  set_file_all_ones_op_ones_a: assert property (
    set_file_all_ones_op |-> ##4 o_file_wr.we && o_file_wr.data == RSSX_ALL_ONES
    && !o_flag_we) else $error("Set file wrong");
  pd_clear_a: assert property (
    slp |-> ##4 !o_status.power_down_flag) else $error("Power-down kept");
  to_set_a: assert property (
    slp |-> ##4 o_status.time_out_flag) else $error("Time-out not set");
  wdt_clear_a: assert property (
    slp |-> ##4 o_wdt_clear) else $error("Watchdog not cleared");
  sleep_halt_a: assert property (
    slp |-> ##4 o_sleeping && o_osc_halt && !o_instr_ready)
    else $error("Sleep not entered");
  wdt_wake_a: assert property (
    o_sleeping && i_wake_wdt |-> ##[1:4] !o_sleeping
    && !o_status.time_out_flag) else $error("Watchdog wake wrong");
  rot_flags_a: assert property (
    rot |-> ##4 o_flag_we) else $error("Rotate flags not written");
  wreg_dest_a: assert property (
    rot && !i_instr[RSSX_BIT_DEST] |-> ##4 o_wreg_we && !o_file_wr.we)
    else $error("Rotate result not sent to W");
endmodule : rssx_exec_checker

// ==== rssx_exec_test.sv ====
// Testbench for the rotate, set-file and sleep execution block
`timescale 1ns/1ps
module rssx_exec_test;
  import rssx_pkg::*;
  logic i_clk = 1'h0, i_resetn = 1'h0, i_instr_valid = 1'h0;
  logic i_ext_set_en = 1'h0;
  logic i_wake_wdt = 1'h0, i_wake_other = 1'h0;
  logic [15:0] i_instr = '0;
  logic [3:0] i_bank_select_reg = '0;
  logic [11:0] i_index_base = '0;
  logic [7:0] i_file_rd_data = '0;
  logic [11:0] o_file_rd_addr;
  rssx_file_wr_t o_file_wr;
  logic o_wreg_we, o_flag_we, o_neg_flag, o_zero_flag;
  logic o_wdt_clear, o_sleeping, o_osc_halt, o_instr_ready;
  logic [7:0] o_wreg_data;
  rssx_status_t o_status;
  rssx_phase_t o_phase;
  int errors = 0, checks = 0;
  rssx_exec rssx_exec_i (.i_clk, .i_resetn, .i_instr_valid, .i_instr,
    .i_ext_set_en, .i_bank_select_reg, .i_index_base, .i_file_rd_data,
    .i_wake_wdt, .i_wake_other, .o_file_rd_addr, .o_file_wr, .o_wreg_we,
    .o_wreg_data, .o_flag_we, .o_neg_flag, .o_zero_flag, .o_status,
    .o_wdt_clear, .o_sleeping, .o_osc_halt, .o_instr_ready, .o_phase);
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  // ********
  // Shared tasks
  // ********
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic exec(input logic [15:0] ins, input logic [7:0] d);
    @(negedge i_clk);
    i_instr = ins;
    i_file_rd_data = d;
    i_instr_valid = 1'h1;
    @(negedge i_clk);
    i_instr_valid = 1'h0;
    repeat (3) @(negedge i_clk);
  endtask : exec
  task automatic end_of_test;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // ********
  // Scenarios
  // ********
  task automatic t_rot_file;
    i_bank_select_reg = 4'h5;
    exec({6'h10, 2'h3, 8'h34}, 8'hD7);
    chk(o_file_wr, {1'h1, 12'h534, 8'hEB});
    chk({o_flag_we, o_neg_flag, o_zero_flag, o_wreg_we}, 4'hC);
    chk(o_file_rd_addr, 12'h534);
  endtask : t_rot_file
  task automatic t_rot_w;
    i_ext_set_en = 1'h1;
    i_index_base = 12'h100;
    exec({6'h10, 2'h0, 8'h5F}, 8'h01);
    chk({o_wreg_we, o_wreg_data, o_file_wr.we}, {1'h1, 8'h80, 1'h0});
    chk(o_file_rd_addr, 12'h15F);
  endtask : t_rot_w
  task automatic t_rot_zero;
    exec({6'h10, 2'h2, 8'h60}, 8'h00);
    chk(o_file_wr, {1'h1, 12'hF60, 8'h00});
    chk({o_neg_flag, o_zero_flag}, 2'h1);
  endtask : t_rot_zero
  task automatic t_set_file_all_ones_op;
    i_ext_set_en = 1'h0;
    exec({7'h34, 1'h0, 8'h12}, 8'h5A);
    chk(o_file_wr, {1'h1, 12'h012, 8'hFF});
    chk({o_flag_we, o_neg_flag, o_zero_flag}, 3'h2);
  endtask : t_set_file_all_ones_op
  task automatic t_sleep(input logic wdt);
    exec(16'h0003, 8'h00);
    chk(o_status, 2'h1);
    chk(o_wdt_clear, 1'h1);
    chk({o_sleeping, o_osc_halt, o_instr_ready}, 3'h6);
    i_wake_wdt = wdt;
    i_wake_other = ~wdt;
    repeat (3) @(negedge i_clk);
    chk({o_sleeping, o_status.time_out_flag}, {1'h0, ~wdt});
    i_wake_wdt = 1'h0;
    i_wake_other = 1'h0;
  endtask : t_sleep
  initial begin
    repeat (16) @(negedge i_clk);
    i_resetn = 1'h1;
    repeat (4) @(negedge i_clk);
    t_rot_file();
    t_rot_w();
    t_rot_zero();
    t_set_file_all_ones_op();
    t_sleep(1'h1);
    t_sleep(1'h0);
    t_rot_file();
    end_of_test();
  end
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
endmodule : rssx_exec_test
bind rssx_exec rssx_exec_checker rssx_exec_checker_i (.i_clk, .i_resetn,
  .i_instr_valid, .i_instr, .i_wake_wdt, .o_file_wr, .o_wreg_we,
  .o_flag_we, .o_status, .o_wdt_clear, .o_sleeping, .o_osc_halt,
  .o_instr_ready, .o_phase);

// ==== rssx_pkg.sv ====
// Package for the rotate, set-file and sleep execution block
package rssx_pkg;

  // ****************************************
  // Opcode fields
  // ****************************************
  localparam logic [5:0] RSSX_OPC_ROTATE_RIGHT_NO_CARRY = 6'h10;
  localparam logic [6:0] RSSX_OPC_SET_FILE_ALL_ONES = 7'h34;
  localparam logic [15:0] RSSX_OPC_SLEEP = 16'h0003;
  localparam int RSSX_OPC6_HI = 15;
  localparam int RSSX_OPC6_LO = 10;
  localparam int RSSX_OPC7_LO = 9;
  localparam int RSSX_BIT_DEST = 9;
  localparam int RSSX_BIT_ACCESS = 8;

  // ****************************************
  // Addressing constants
  // ****************************************
  localparam logic [7:0] RSSX_INDEXED_MAX = 8'h5F;
  localparam logic [7:0] RSSX_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] RSSX_ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] RSSX_ACCESS_HIGH_BANK = 4'hF;
  localparam logic [7:0] RSSX_ALL_ONES = 8'hFF;
  localparam logic [7:0] RSSX_ZERO_BYTE = 8'h00;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RSSX_PD_RESET = 1'b1;
  localparam logic RSSX_TO_RESET = 1'b1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    RSSX_Q_DECODE = 4'b0001,
    RSSX_Q_READ = 4'b0010,
    RSSX_Q_PROCESS = 4'b0100,
    RSSX_Q_WRITE = 4'b1000
  } rssx_phase_t;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } rssx_file_wr_t;

  typedef struct packed {
    logic power_down_flag;
    logic time_out_flag;
  } rssx_status_t;

endpackage : rssx_pkg
